// ===== bstap_top.sv
// Boundary-scan test access port: controller, instruction register,
// bypass, identification and boundary registers, pad output muxing.
// Assumes the test pins and pads are asynchronous to CLK and that CLK
// runs several times faster than the test clock.
//
// Operation
// - Reset state holds identification instruction, normal operation
// - Mode select sampled on rising test clock
// - Select-DR: low to capture, high to select-IR
// - Capture-DR loads selected register; then shift/exit1
// - Shift-DR moves selected register toward output
// - Exit1-DR: high to update, low to pause
// - Pause-DR holds; high goes to exit2
// - Exit2-DR: high to update, low to shift
// - Update-DR falling edge copies shift to latches
// - Select-IR: low to capture, high to reset
// - Capture-IR loads fixed constant; then shift/exit1
// - Shift-IR shifts instruction; current instruction unchanged
// - Exit1-IR low to pause; pause holds while low
// - Exit1/exit2-IR high goes to update-IR
// - Update-IR falling edge latches current instruction
// - Instruction register three bits, shift plus latch
// - Codes: sample 010, bypass 111, extest 000
// - Codes: clamp 011, highz 100, identification 001
// - Sample captures pins, preload shifts without disturbing
// - Bypass uses one stage, normal operation kept
// - Extest drives outputs from boundary latches
// - Clamp holds latched outputs; highz floats outputs
`timescale 1ns/1ps
`default_nettype none

module bstap_top
    import bstap_pkg::*;
#(
    parameter int unsigned          BSR_LEN = 8,
    parameter logic [ID_WIDTH-1:0]  ID_CODE = 32'h1234_5679  // Arbitrary value, LSB must be 1
) (
    input  wire logic               CLK,
    input  wire logic               RST_N,
    input  wire logic               TEST_RESET_N,
    input  wire logic               TEST_CLOCK,
    input  wire logic               TEST_MODE_SELECT,
    input  wire logic               TEST_DATA_IN,
    output logic                    TEST_DATA_OUT,
    output logic                    TEST_DATA_OUT_OE,
    input  wire logic [BSR_LEN-1:0] CORE_OUT,
    input  wire logic [BSR_LEN-1:0] CORE_OE,
    input  wire logic [BSR_LEN-1:0] PAD_IN,
    output logic      [BSR_LEN-1:0] PAD_OUT,
    output logic      [BSR_LEN-1:0] PAD_OE
);

    // ------------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------------
    if (BSR_LEN < 1) begin : g_bad_len
        $error("BSR_LEN must be at least 1");
    end
    if (ID_CODE[0] != 1'b1) begin : g_bad_id
        $error("ID_CODE must have bit 0 set");
    end

    // ------------------------------------------------------------------
    // State record
    // ------------------------------------------------------------------
    typedef struct packed {
        logic                tck_m;
        logic                tck_s;
        logic                tck_p;
        logic                tms_m;
        logic                tms_s;
        logic                tdi_m;
        logic                tdi_s;
        logic                trst_m;
        logic                trst_s;
        logic [BSR_LEN-1:0]  pad_m;
        logic [BSR_LEN-1:0]  pad_s;
        bstap_state_type     st;
        logic [IR_WIDTH-1:0] ir_sh;
        logic [IR_WIDTH-1:0] ir_cur;
        logic                byp;
        logic [ID_WIDTH-1:0] id_sh;
        logic [BSR_LEN-1:0]  bsr_sh;
        logic [BSR_LEN-1:0]  bsr_lat;
        logic                tdo;
        logic                tdo_oe;
        logic [BSR_LEN-1:0]  pad_out;
        logic [BSR_LEN-1:0]  pad_oe;
    } bstap_regs_type;

    bstap_regs_type q;
    bstap_regs_type d;

    logic       tck_rise;
    logic       tck_fall;
    logic [1:0] dr_sel;

    // ------------------------------------------------------------------
    // Controller next state
    // ------------------------------------------------------------------
    function automatic bstap_state_type next_state(input bstap_state_type s,
                                                   input logic tms);
        bstap_state_type n;
        n = s;
        case (s)
            ST_TLR:    n = tms ? ST_TLR : ST_RTI;
            ST_RTI:    n = tms ? ST_SEL_DR : ST_RTI;
            ST_SEL_DR: n = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: n = tms ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR:  n = tms ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: n = tms ? ST_UPD_DR : ST_PA_DR;
            ST_PA_DR:  n = tms ? ST_EX2_DR : ST_PA_DR;
            ST_EX2_DR: n = tms ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: n = tms ? ST_SEL_DR : ST_RTI;
            ST_SEL_IR: n = tms ? ST_TLR : ST_CAP_IR;
            ST_CAP_IR: n = tms ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR:  n = tms ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: n = tms ? ST_UPD_IR : ST_PA_IR;
            ST_PA_IR:  n = tms ? ST_EX2_IR : ST_PA_IR;
            ST_EX2_IR: n = tms ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: n = tms ? ST_SEL_DR : ST_RTI;
            default:   n = ST_TLR;
        endcase
        return n;
    endfunction : next_state

    // ------------------------------------------------------------------
    // Instruction decode to data register
    // ------------------------------------------------------------------
    function automatic logic [1:0] select_dr(input logic [IR_WIDTH-1:0] ir);
        logic [1:0] r;
        r = SEL_BYPASS;
        case (ir)
            IR_SAMPLE: r = SEL_BSR;
            IR_EXTEST: r = SEL_BSR;
            IR_IDCODE: r = SEL_IDENT;
            IR_BYPASS: r = SEL_BYPASS;
            IR_CLAMP:  r = SEL_BYPASS;
            IR_HIGHZ:  r = SEL_BYPASS;
            default:   r = SEL_BYPASS;
        endcase
        return r;
    endfunction : select_dr

    // Test clock edges found from the synchronised level
    assign tck_rise = q.tck_s & ~q.tck_p;
    assign tck_fall = ~q.tck_s & q.tck_p;
    assign dr_sel = select_dr(q.ir_cur);

    // ------------------------------------------------------------------
    // Next-value logic
    // ------------------------------------------------------------------
    always_comb begin
        d = q;
        // Two-stage synchronisers for pins
        d.tck_m = TEST_CLOCK;
        d.tck_s = q.tck_m;
        d.tck_p = q.tck_s;
        d.tms_m = TEST_MODE_SELECT;
        d.tms_s = q.tms_m;
        d.tdi_m = TEST_DATA_IN;
        d.tdi_s = q.tdi_m;
        d.trst_m = TEST_RESET_N;
        d.trst_s = q.trst_m;
        d.pad_m = PAD_IN;
        d.pad_s = q.pad_m;

        if (!q.trst_s) begin
            // Test reset acts without waiting for a test clock edge
            d.st = ST_TLR;
            d.ir_cur = IR_IDCODE;
            d.tdo_oe = 1'b0;
        end else if (tck_rise) begin
            d.st = next_state(q.st, q.tms_s);
            case (q.st)
                ST_CAP_DR: begin
                    // Parallel load of the selected register
                    case (dr_sel)
                        SEL_BSR:   d.bsr_sh = q.pad_s;
                        SEL_IDENT: d.id_sh = ID_CODE;
                        default:   d.byp = BYPASS_CAPTURE;
                    endcase
                end
                ST_SH_DR: begin
                    // Only the selected register moves
                    case (dr_sel)
                        SEL_BSR:   d.bsr_sh = {q.tdi_s, q.bsr_sh[BSR_LEN-1:1]};
                        SEL_IDENT: d.id_sh = {q.tdi_s, q.id_sh[ID_WIDTH-1:1]};
                        default:   d.byp = q.tdi_s;
                    endcase
                end
                ST_CAP_IR: d.ir_sh = IR_CAPTURE;
                ST_SH_IR:  d.ir_sh = {q.tdi_s, q.ir_sh[IR_WIDTH-1:1]};
                default:   d.ir_sh = q.ir_sh;               // Pause and select states hold
            endcase
        end else if (tck_fall) begin
            // Falling edge: output latches and serial output
            case (q.st)
                ST_UPD_DR: begin
                    if (dr_sel == SEL_BSR) begin
                        d.bsr_lat = q.bsr_sh;
                    end
                end
                ST_UPD_IR: d.ir_cur = q.ir_sh;
                default:   d.ir_cur = q.ir_cur;
            endcase
            d.tdo_oe = (q.st == ST_SH_DR) || (q.st == ST_SH_IR);
            if (q.st == ST_SH_IR) begin
                d.tdo = q.ir_sh[0];
            end else begin
                case (dr_sel)
                    SEL_BSR:   d.tdo = q.bsr_sh[0];
                    SEL_IDENT: d.tdo = q.id_sh[0];
                    default:   d.tdo = q.byp;
                endcase
            end
        end

        // Reset state forces the identification instruction
        if (q.st == ST_TLR) begin
            d.ir_cur = IR_IDCODE;
        end

        // Pad muxing from the current instruction
        case (q.ir_cur)
            IR_EXTEST, IR_CLAMP: begin
                d.pad_out = q.bsr_lat;
                d.pad_oe = {BSR_LEN{1'b1}};
            end
            IR_HIGHZ: begin
                d.pad_out = CORE_OUT;
                d.pad_oe = {BSR_LEN{1'b0}};
            end
            default: begin
                d.pad_out = CORE_OUT;
                d.pad_oe = CORE_OE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            q <= '0;
            q.trst_m <= 1'b1;                               // Test reset pin idles high
            q.trst_s <= 1'b1;
            q.st <= ST_TLR;
            q.ir_cur <= IR_IDCODE;
            q.ir_sh <= IR_CAPTURE;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state record
    assign TEST_DATA_OUT = q.tdo;
    assign TEST_DATA_OUT_OE = q.tdo_oe;
    assign PAD_OUT = q.pad_out;
    assign PAD_OE = q.pad_oe;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_test_reset;
        @(posedge CLK) disable iff (!RST_N)
        !q.trst_s |=> (q.st == ST_TLR) && (q.ir_cur == IR_IDCODE);
    endproperty
    a_test_reset: assert property (p_test_reset)
        else $error("test reset did not force reset state");

    property p_sel_dr;
        @(posedge CLK) disable iff (!RST_N)
        (q.trst_s && tck_rise && q.st == ST_SEL_DR)
            |=> (q.st == ($past(q.tms_s) ? ST_SEL_IR : ST_CAP_DR));
    endproperty
    a_sel_dr: assert property (p_sel_dr)
        else $error("select-DR went to the wrong state");

    property p_exit1_dr;
        @(posedge CLK) disable iff (!RST_N)
        (q.trst_s && tck_rise && q.st == ST_EX1_DR && q.tms_s) |=> q.st == ST_UPD_DR;
    endproperty
    a_exit1_dr: assert property (p_exit1_dr)
        else $error("exit1-DR with select high missed update-DR");

    property p_pause_dr;
        @(posedge CLK) disable iff (!RST_N)
        (q.trst_s && q.st == ST_PA_DR && !(tck_rise && q.tms_s))
            |=> (q.st == ST_PA_DR) && $stable(q.bsr_sh) && $stable(q.id_sh);
    endproperty
    a_pause_dr: assert property (p_pause_dr)
        else $error("pause-DR did not hold");

    property p_exit2_dr;
        @(posedge CLK) disable iff (!RST_N)
        (q.trst_s && tck_rise && q.st == ST_EX2_DR && !q.tms_s) |=> q.st == ST_SH_DR;
    endproperty
    a_exit2_dr: assert property (p_exit2_dr)
        else $error("exit2-DR with select low missed shift-DR");

    property p_exit2_ir;
        @(posedge CLK) disable iff (!RST_N)
        (q.trst_s && tck_rise && q.st == ST_EX2_IR)
            |=> (q.st == ($past(q.tms_s) ? ST_UPD_IR : ST_SH_IR));
    endproperty
    a_exit2_ir: assert property (p_exit2_ir)
        else $error("exit2-IR went to the wrong state");

    property p_capture_ir;
        @(posedge CLK) disable iff (!RST_N)
        (q.trst_s && tck_rise && q.st == ST_CAP_IR) |=> q.ir_sh == IR_CAPTURE;
    endproperty
    a_capture_ir: assert property (p_capture_ir)
        else $error("capture-IR did not load the fixed pattern");

    property p_update_ir;
        @(posedge CLK) disable iff (!RST_N)
        (q.trst_s && tck_fall && q.st == ST_UPD_IR) |=> q.ir_cur == $past(q.ir_sh);
    endproperty
    a_update_ir: assert property (p_update_ir)
        else $error("update-IR did not latch the instruction");

    property p_shift_ir_keeps;
        @(posedge CLK) disable iff (!RST_N)
        (q.trst_s && q.st == ST_SH_IR) |=> $stable(q.ir_cur) && $stable(q.bsr_lat);
    endproperty
    a_shift_ir_keeps: assert property (p_shift_ir_keeps)
        else $error("current instruction changed during shift-IR");

    property p_bypass_shift;
        @(posedge CLK) disable iff (!RST_N)
        (q.trst_s && tck_rise && q.st == ST_SH_DR && q.ir_cur == IR_BYPASS)
            |=> q.byp == $past(q.tdi_s);
    endproperty
    a_bypass_shift: assert property (p_bypass_shift)
        else $error("bypass stage did not take the input bit");

    property p_highz;
        @(posedge CLK) disable iff (!RST_N)
        (q.ir_cur == IR_HIGHZ) |=> q.pad_oe == '0;
    endproperty
    a_highz: assert property (p_highz)
        else $error("pads driven under high-impedance instruction");

    property p_extest;
        @(posedge CLK) disable iff (!RST_N)
        (q.ir_cur == IR_EXTEST) |=> (q.pad_out == $past(q.bsr_lat)) && (q.pad_oe == '1);
    endproperty
    a_extest: assert property (p_extest)
        else $error("pads not driven from boundary latches");

endmodule : bstap_top

`default_nettype wire

// ===== bstap_pkg.sv
// Package for the boundary-scan test access port.
// Assumes a single system clock that oversamples the test clock pins.
package bstap_pkg;

    // ------------------------------------------------------------------
    // Instruction register
    // ------------------------------------------------------------------
    localparam int unsigned IR_WIDTH = 3;
    localparam logic [2:0] IR_EXTEST = 3'h0;
    localparam logic [2:0] IR_IDCODE = 3'h1;
    localparam logic [2:0] IR_SAMPLE = 3'h2;
    localparam logic [2:0] IR_CLAMP = 3'h3;
    localparam logic [2:0] IR_HIGHZ = 3'h4;
    localparam logic [2:0] IR_BYPASS = 3'h7;
    localparam logic [2:0] IR_CAPTURE = 3'h1;    // Fixed pattern, low bits 01

    // ------------------------------------------------------------------
    // Data register selection and widths
    // ------------------------------------------------------------------
    localparam logic [1:0] SEL_BYPASS = 2'h0;
    localparam logic [1:0] SEL_BSR = 2'h1;
    localparam logic [1:0] SEL_IDENT = 2'h2;
    localparam int unsigned ID_WIDTH = 32;
    localparam logic BYPASS_CAPTURE = 1'h0;

    // ------------------------------------------------------------------
    // Controller states
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_TLR     = 4'hF,
        ST_RTI     = 4'hC,
        ST_SEL_DR  = 4'h7,
        ST_CAP_DR  = 4'h6,
        ST_SH_DR   = 4'h2,
        ST_EX1_DR  = 4'h1,
        ST_PA_DR   = 4'h3,
        ST_EX2_DR  = 4'h0,
        ST_UPD_DR  = 4'h5,
        ST_SEL_IR  = 4'h4,
        ST_CAP_IR  = 4'hE,
        ST_SH_IR   = 4'hA,
        ST_EX1_IR  = 4'h9,
        ST_PA_IR   = 4'hB,
        ST_EX2_IR  = 4'h8,
        ST_UPD_IR  = 4'hD
    } bstap_state_type;

endpackage : bstap_pkg

// ===== bstap_tester.sv
// Model of the external boundary-scan tester that drives the test pins.
// Assumes CLK is the system clock; the test clock is made as 8 CLK periods
// and stands low between scans.
`timescale 1ns/1ps
`default_nettype none

module bstap_tester (
    input  wire logic clk,
    input  wire logic tdo,
    input  wire logic tdo_oe,
    output logic      tck,
    output logic      tms,
    output logic      tdi
);
    // ------------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------------
    // Idle levels at time zero
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // Wait n CLK edges, then step just past the edge
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_clk

    // One test clock period; data out is taken just before the next fall
    task automatic bit_io(input logic m, input logic d, output logic q, output logic q_oe);
        tms = m;            // Set up well before the rising edge
        tdi = d;
        wait_clk(4);
        tck = 1'b1;
        wait_clk(4);
        q = tdo;
        q_oe = tdo_oe;
        tck = 1'b0;
    endtask : bit_io

    // Single step with a given mode select
    task automatic step(input logic m);
        logic q;
        logic qe;
        bit_io(m, ~tdi, q, qe);
    endtask : step

    // Full IR or DR scan from run-test-idle back to run-test-idle
    task automatic scan(input logic is_ir, input int n, input logic [39:0] din,
                        input logic pause, output logic [39:0] dout, output logic oe_ok);
        logic q;
        logic qe;
        int   i;
        dout = '0;
        oe_ok = 1'b1;
        bit_io(1'b1, 1'b0, q, qe);
        if (is_ir) begin
            bit_io(1'b1, 1'b1, q, qe);
        end
        bit_io(1'b0, 1'b0, q, qe);
        bit_io(1'b0, 1'b1, q, qe);
        for (i = 0; i < n; i++) begin
            bit_io((i == n - 1) || (pause && i == n - 2), din[i], q, qe);
            dout[i] = q;
            oe_ok = oe_ok & qe;
            // Pause, stay, exit2, back to shift
            if (pause && i == n - 2) begin
                bit_io(1'b0, ~din[i], q, qe);
                bit_io(1'b0, din[i], q, qe);
                bit_io(1'b1, ~din[i], q, qe);
                bit_io(1'b0, din[i], q, qe);
            end
        end
        bit_io(1'b1, 1'b0, q, qe);
        bit_io(1'b0, 1'b1, q, qe);
        wait_clk(6);
    endtask : scan
endmodule : bstap_tester

`default_nettype wire

// ===== bstap_tb.sv
// Self-checking bench for the boundary-scan test access port.
// Assumes bstap_pkg, bstap_top and bstap_tester are compiled first.
`timescale 1ns/1ps
`default_nettype none

module tb;
    import bstap_pkg::*;
    // ------------------------------------------------------------------
    // Setup
    // ------------------------------------------------------------------
    localparam int unsigned         BSR_LEN = 8;
    localparam logic [ID_WIDTH-1:0] ID_VAL  = 32'h5A3C_0E71;  // Arbitrary value, LSB 1
    localparam logic [39:0]         DIN     = 40'hA5_C3F0_96E1;

    logic               clk = 1'b0;
    logic               rst_n;
    logic               test_reset_n;
    logic [BSR_LEN-1:0] core_out;
    logic [BSR_LEN-1:0] core_oe;
    logic [BSR_LEN-1:0] pad_in;
    logic               tck, tms, tdi, tdo, tdo_oe;
    logic [BSR_LEN-1:0] pad_out, pad_oe;
    int                 failures = 0;
    int                 checked = 0;

    // 25 MHz system clock
    always #20 clk = ~clk;

    bstap_top #(.BSR_LEN(BSR_LEN), .ID_CODE(ID_VAL)) DUT (
        .CLK(clk), .RST_N(rst_n), .TEST_RESET_N(test_reset_n),
        .TEST_CLOCK(tck), .TEST_MODE_SELECT(tms), .TEST_DATA_IN(tdi),
        .TEST_DATA_OUT(tdo), .TEST_DATA_OUT_OE(tdo_oe),
        .CORE_OUT(core_out), .CORE_OE(core_oe), .PAD_IN(pad_in),
        .PAD_OUT(pad_out), .PAD_OE(pad_oe)
    );

    bstap_tester PARTNER (
        .clk(clk), .tdo(tdo), .tdo_oe(tdo_oe), .tck(tck), .tms(tms), .tdi(tdi)
    );

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    // Compare and count
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Load an instruction and judge the captured pattern
    task automatic load_ir(input logic [2:0] code, input logic pause);
        logic [39:0] q;
        logic        ok;
        PARTNER.scan(1'b1, 3, {37'h0, code}, pause, q, ok);
        check(q[2:0], IR_CAPTURE);
        check(ok, 1'b1);
    endtask : load_ir

    // A 40-bit data scan shows the captured value then input delayed by len
    task automatic dr_len(input int len, input logic [39:0] cap, input logic pause);
        logic [39:0] q;
        logic        ok;
        PARTNER.scan(1'b0, 40, DIN, pause, q, ok);
        check(q, (DIN << len) | cap);
        check(ok, 1'b1);
        check(tdo_oe, 1'b0);
    endtask : dr_len

    // Walk the controller with mode select values, bit 0 first
    task automatic walk(input logic [7:0] seq, input int n);
        for (int k = 0; k < n; k++) begin
            PARTNER.step(seq[k]);
        end
    endtask : walk

    // Ends the run with the counts and verdict
    task automatic print_verdict();
        $display("Counts: %0d comparisons, %0d mismatches", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : print_verdict

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // After reset: identification selected, pads follow the core
    task automatic t_reset_state();
        PARTNER.step(1'b0);
        check(pad_out, core_out);
        check(pad_oe, core_oe);
        dr_len(32, ID_VAL, 1'b0);
        $display("test reset_state done");
    endtask : t_reset_state

    // Every code, including unknown ones, selects the right register
    task automatic t_codes();
        logic [2:0]  c;
        int          len;
        logic [39:0] cap;
        for (int i = 0; i < 8; i++) begin
            c = i[2:0];
            pad_in = {c, 5'h0D};
            load_ir(c, c[0]);
            len = (c == IR_EXTEST || c == IR_SAMPLE) ? BSR_LEN : (c == IR_IDCODE) ? 32 : 1;
            cap = (len == BSR_LEN) ? {32'h0, pad_in} : (len == 32) ? {8'h0, ID_VAL} : 40'h0;
            dr_len(len, cap, c[1]);
        end
        $display("test codes done");
    endtask : t_codes

    // Preload, extest, clamp, highz and bypass effect on the pads
    task automatic t_pads();
        logic [39:0] q;
        logic        ok;
        load_ir(IR_SAMPLE, 1'b0);
        PARTNER.scan(1'b0, BSR_LEN, 40'h3C, 1'b0, q, ok);
        check(pad_out, core_out);
        load_ir(IR_EXTEST, 1'b0);
        check(pad_out, 8'h3C);
        check(pad_oe, 8'hFF);
        PARTNER.scan(1'b0, BSR_LEN, 40'hA6, 1'b1, q, ok);
        check(q[7:0], pad_in);
        check(pad_out, 8'hA6);
        // Capture then update with no shift: latches take the sampled pads
        pad_in = 8'h4B;
        walk(8'h35, 7);
        check(pad_out, 8'h4B);
        @(posedge clk) #1;
        core_out = 8'h21;
        core_oe = 8'h1F;
        load_ir(IR_CLAMP, 1'b1);
        check(pad_out, 8'h4B);
        load_ir(IR_HIGHZ, 1'b0);
        check(pad_oe, 8'h00);
        load_ir(IR_BYPASS, 1'b0);
        check(pad_out, core_out);
        check(pad_oe, core_oe);
        $display("test pads done");
    endtask : t_pads

    // Test reset pin and select-IR exit both restore identification
    task automatic t_resets();
        load_ir(IR_EXTEST, 1'b0);
        @(posedge clk) #1;
        test_reset_n = 1'b0;
        PARTNER.wait_clk(4);
        test_reset_n = 1'b1;
        PARTNER.wait_clk(4);
        check(pad_out, core_out);
        PARTNER.step(1'b0);
        dr_len(32, ID_VAL, 1'b0);
        load_ir(IR_BYPASS, 1'b0);
        // Capture-IR straight to exit1, pause, exit2 high to update
        walk(8'h6B, 8);
        dr_len(32, ID_VAL, 1'b0);
        load_ir(IR_BYPASS, 1'b0);
        dr_len(1, 40'h0, 1'b0);
        walk(8'h07, 4);
        dr_len(32, ID_VAL, 1'b0);
        $display("test resets done");
    endtask : t_resets

    // ------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        test_reset_n = 1'b1;
        core_out = 8'h5A;
        core_oe = 8'hC3;
        pad_in = 8'h96;
        repeat (16) @(posedge clk);
        #1;
        rst_n = 1'b1;
        PARTNER.wait_clk(4);
        t_reset_state();
        t_codes();
        t_pads();
        t_resets();
        print_verdict();
    end

    // Cuts a hang short; the tests take well under a millisecond
    initial begin
        #2_000_000;
        failures++;
        $display("ERROR at %0t ns: watchdog expired", $time);
        print_verdict();
    end
endmodule : tb

`default_nettype wire
